// [guard_timer_block.sv]
// Purpose: Watchdog timer with its interval time base behind a Wishbone slave.
// Assumes: Classic Wishbone, 32-bit data, registers in the low byte lane.
// Notes: A match raises an interrupt flag or a one-cycle CPU reset request.
//
// Contract
// - Interval flag reads one after interval interrupt.
// - Interval clear bit zeroes the interval counter.
// - Period select picks overflow of bit 0..7.
// - Guard counter equal to match raises flag.
// - Reset-on-match zero: timer; one: reset mode.
// - Match gives interrupt, or reset when selected.
// - Guard clear bit zeroes counter, self-clears; the code zeroes it only while the enable bit is set.
// - Clock select: interval overflow or RC oscillator.
// - Guard interval is period times match plus one.
// - Count read and match write share address.
// - Enable bit stops or runs the guard timer.
// - Guard flag cleared by zero write or acknowledge.
// - Interval counter runs freely, cannot be halted.
// - Interval clear bit self-clears after one cycle.
// - Interval flag cleared by zero write or acknowledge.
//
// Added by the designer: register access over Wishbone.
`timescale 1ns/1ps
module guard_timer_block
    import guard_timer_pkg::*;
#(
    parameter int unsigned INTERVAL_DIV = INTERVAL_DIV_DEFAULT
)
(
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [DATA_W-1:0] wb_dat_i,
    output logic [DATA_W-1:0] wb_dat_o,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic wb_ack_o,
    input wire logic rc_clk_i,
    input wire logic interval_irq_ack_i,
    input wire logic guard_irq_ack_i,
    output logic interval_irq_flag_o,
    output logic guard_irq_flag_o,
    output logic irq_o,
    output logic cpu_reset_req_o,
    output logic rc_osc_enable_o
);

    // ****************************************************************
    // State.
    // ****************************************************************
    typedef struct packed {
        logic ack;
        logic [DATA_W-1:0] rdata;
        logic interval_irq_flag;
        logic interval_count_clear;
        logic [2:0] interval_period_select;
        logic guard_enable;
        logic reset_on_match;
        logic guard_counter_clear;
        logic guard_clock_select;
        logic guard_irq_flag;
        logic [7:0] guard_count;
        logic [7:0] guard_match_value;
        logic [EV_W-1:0] status;
        logic [EV_W-1:0] mask;
        logic irq;
        logic reset_req;
    } block_state_t;

    block_state_t st_ff;
    block_state_t nxt_st;

    logic [7:0] interval_count;
    logic interval_overflow;
    logic rc_rise;
    logic guard_tick;
    logic guard_match;
    logic bus_req;
    logic bus_write;
    logic [7:0] wbyte;
    logic [EV_W-1:0] events;

    // ****************************************************************
    // Time base and RC oscillator tick.
    // ****************************************************************
    interval_base #(
        .DIV(INTERVAL_DIV)
    ) u_interval_base (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .clear_i(st_ff.interval_count_clear),
        .period_sel_i(st_ff.interval_period_select),
        .count_o(interval_count),
        .overflow_o(interval_overflow)
    );

    rc_tick_sync u_rc_tick_sync (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .rc_clk_i(rc_clk_i),
        .rise_o(rc_rise)
    );

    // ****************************************************************
    // Register read view.
    // ****************************************************************
    function automatic logic [7:0] read_view(input block_state_t s,
                                             input logic [ADDR_W-1:0] adr,
                                             input logic [7:0] icount);
        logic [7:0] v;
        v = 8'h00;
        if (adr == byte_addr(IDX_INTERVAL_CONTROL)) begin
            v[IC_FLAG_BIT] = s.interval_irq_flag;
            v[IC_CLEAR_BIT] = s.interval_count_clear;
            v[IC_PERIOD_LSB +: 3] = s.interval_period_select;
        end else if (adr == byte_addr(IDX_INTERVAL_COUNT)) begin
            v = icount;
        end else if (adr == byte_addr(IDX_GUARD_CONTROL)) begin
            v[GC_ENABLE_BIT] = s.guard_enable;
            v[GC_RESET_ON_MATCH_BIT] = s.reset_on_match;
            v[GC_CLEAR_BIT] = s.guard_counter_clear;
            v[GC_CLOCK_SELECT_BIT] = s.guard_clock_select;
            v[GC_FLAG_BIT] = s.guard_irq_flag;
        end else if (adr == byte_addr(IDX_GUARD_COUNT)) begin
            v = s.guard_count;
        end else if (adr == byte_addr(IDX_EVENT_STATUS)) begin
            v[EV_W-1:0] = s.status;
        end else if (adr == byte_addr(IDX_EVENT_MASK)) begin
            v[EV_W-1:0] = s.mask;
        end
        read_view = v;
    endfunction

    // ****************************************************************
    // Next-state logic.
    // ****************************************************************
    always_comb begin
        nxt_st = st_ff;
        events = '0;
        wbyte = wb_dat_i[7:0];
        bus_req = wb_cyc_i & wb_stb_i;
        bus_write = bus_req & st_ff.ack & wb_we_i & wb_sel_i[0];

        // Bus handshake: data is set up with ack; the write is taken in the ack cycle and lands one cycle later.
        nxt_st.ack = bus_req & ~st_ff.ack;
        if (bus_req & ~st_ff.ack) begin
            nxt_st.rdata = {24'h00_0000, read_view(st_ff, wb_adr_i, interval_count)};
        end

        // Self-clearing control bits hold for exactly one cycle.
        nxt_st.interval_count_clear = 1'b0;
        nxt_st.guard_counter_clear = 1'b0;
        nxt_st.reset_req = 1'b0;

        // Guard counter.
        guard_tick = st_ff.guard_clock_select ? rc_rise : interval_overflow;
        guard_match = 1'b0;
        if (st_ff.guard_enable) begin
            if (st_ff.guard_counter_clear) begin
                nxt_st.guard_count = COUNT_RESET;
            end else if (guard_tick) begin
                if (st_ff.guard_count == st_ff.guard_match_value) begin
                    nxt_st.guard_count = COUNT_RESET;
                    guard_match = 1'b1;
                end else begin
                    nxt_st.guard_count = st_ff.guard_count + 8'h01;
                end
            end
        end

        events[EV_INTERVAL_BIT] = interval_overflow;
        events[EV_GUARD_BIT] = guard_match & ~st_ff.reset_on_match;
        events[EV_GUARD_RESET_BIT] = guard_match & st_ff.reset_on_match;

        // Register writes.
        if (bus_write) begin
            if (wb_adr_i == byte_addr(IDX_INTERVAL_CONTROL)) begin
                if (!wbyte[IC_FLAG_BIT]) begin
                    nxt_st.interval_irq_flag = 1'b0;
                end
                nxt_st.interval_count_clear = wbyte[IC_CLEAR_BIT];
                nxt_st.interval_period_select = wbyte[IC_PERIOD_LSB +: 3];
            end
            if (wb_adr_i == byte_addr(IDX_GUARD_CONTROL)) begin
                nxt_st.guard_enable = wbyte[GC_ENABLE_BIT];
                nxt_st.reset_on_match = wbyte[GC_RESET_ON_MATCH_BIT];
                nxt_st.guard_counter_clear = wbyte[GC_CLEAR_BIT];
                nxt_st.guard_clock_select = wbyte[GC_CLOCK_SELECT_BIT];
                if (!wbyte[GC_FLAG_BIT]) begin
                    nxt_st.guard_irq_flag = 1'b0;
                end
            end
            if (wb_adr_i == byte_addr(IDX_GUARD_COUNT)) begin
                nxt_st.guard_match_value = wbyte;
            end
            if (wb_adr_i == byte_addr(IDX_EVENT_STATUS)) begin
                nxt_st.status = st_ff.status & ~wbyte[EV_W-1:0];
            end
            if (wb_adr_i == byte_addr(IDX_EVENT_MASK)) begin
                nxt_st.mask = wbyte[EV_W-1:0];
            end
        end

        // Interrupt acknowledge clears the documented flags.
        if (interval_irq_ack_i) begin
            nxt_st.interval_irq_flag = 1'b0;
        end
        if (guard_irq_ack_i) begin
            nxt_st.guard_irq_flag = 1'b0;
        end

        // Hardware events win over any clear in the same cycle.
        if (events[EV_INTERVAL_BIT]) begin
            nxt_st.interval_irq_flag = 1'b1;
        end
        if (events[EV_GUARD_BIT]) begin
            nxt_st.guard_irq_flag = 1'b1;
        end
        if (events[EV_GUARD_RESET_BIT]) begin
            nxt_st.reset_req = 1'b1;
        end
        nxt_st.status = nxt_st.status | events;
        nxt_st.irq = |(nxt_st.status & nxt_st.mask);
    end

    // ****************************************************************
    // Registers.
    // ****************************************************************
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            st_ff <= '0;
            st_ff.interval_period_select <= INTERVAL_PERIOD_RESET;
            st_ff.guard_match_value <= GUARD_MATCH_RESET;
            st_ff.guard_count <= COUNT_RESET;
            st_ff.status <= EVENT_RESET;
            st_ff.mask <= EVENT_RESET;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ****************************************************************
    // Outputs.
    // ****************************************************************
    assign wb_ack_o = st_ff.ack;
    assign wb_dat_o = st_ff.rdata;
    assign interval_irq_flag_o = st_ff.interval_irq_flag;
    assign guard_irq_flag_o = st_ff.guard_irq_flag;
    assign irq_o = st_ff.irq;
    assign cpu_reset_req_o = st_ff.reset_req;
    assign rc_osc_enable_o = st_ff.guard_clock_select;

endmodule

// [guard_timer_pkg.sv]
// Purpose: Shared constants for the interval timer and guard timer block.
// Assumes: Registers are eight bits wide and sit at word index times four.
// Notes: Offsets are register indices; byte address is index shifted by two.
package guard_timer_pkg;

    // ****************************************************************
    // Bus geometry.
    // ****************************************************************
    localparam int unsigned ADDR_W = 10;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned REG_W = 8;

    // ****************************************************************
    // Register indices.
    // ****************************************************************
    localparam logic [7:0] IDX_INTERVAL_CONTROL = 8'h8b;
    localparam logic [7:0] IDX_INTERVAL_COUNT = 8'h8c;
    localparam logic [7:0] IDX_GUARD_CONTROL = 8'h8d;
    localparam logic [7:0] IDX_GUARD_COUNT = 8'h8e;
    localparam logic [7:0] IDX_EVENT_STATUS = 8'h90;
    localparam logic [7:0] IDX_EVENT_MASK = 8'h91;

    // ****************************************************************
    // Field positions.
    // ****************************************************************
    localparam int unsigned IC_FLAG_BIT = 7;
    localparam int unsigned IC_CLEAR_BIT = 3;
    localparam int unsigned IC_PERIOD_LSB = 0;
    localparam int unsigned GC_ENABLE_BIT = 7;
    localparam int unsigned GC_RESET_ON_MATCH_BIT = 6;
    localparam int unsigned GC_CLEAR_BIT = 5;
    localparam int unsigned GC_CLOCK_SELECT_BIT = 1;
    localparam int unsigned GC_FLAG_BIT = 0;
    localparam int unsigned EV_INTERVAL_BIT = 0;
    localparam int unsigned EV_GUARD_BIT = 1;
    localparam int unsigned EV_GUARD_RESET_BIT = 2;
    localparam int unsigned EV_W = 3;

    // ****************************************************************
    // Reset values.
    // ****************************************************************
    localparam logic [2:0] INTERVAL_PERIOD_RESET = 3'h1;
    localparam logic [7:0] GUARD_MATCH_RESET = 8'hff;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [2:0] EVENT_RESET = 3'h0;

    // ****************************************************************
    // Timing.
    // ****************************************************************
    localparam int unsigned INTERVAL_DIV_DEFAULT = 16;

    // Turns a register index into its byte address on the bus.
    function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] idx);
        byte_addr = {idx, 2'b00};
    endfunction

endpackage

// [rc_tick_sync.sv]
// Purpose: Brings the watchdog RC oscillator pin into the system clock domain.
// Assumes: The RC clock is much slower than the system clock.
// Notes: Emits a one-cycle pulse per rising edge of the RC clock.
`timescale 1ns/1ps
module rc_tick_sync
    import guard_timer_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic rc_clk_i,
    output logic rise_o
);

    typedef struct packed {
        logic meta;
        logic sync;
        logic last;
        logic rise;
    } sync_state_t;

    sync_state_t st_ff;
    sync_state_t nxt_st;

    // ****************************************************************
    // Two-stage synchroniser and edge detector.
    // ****************************************************************
    always_comb begin
        nxt_st = st_ff;
        nxt_st.meta = rc_clk_i;
        nxt_st.sync = st_ff.meta;
        nxt_st.last = st_ff.sync;
        nxt_st.rise = st_ff.sync & ~st_ff.last;
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign rise_o = st_ff.rise;

endmodule

// [interval_base.sv]
// Purpose: Free-running eight-bit interval counter with selectable overflow.
// Assumes: The interval clock is the system clock divided by DIV.
// Notes: Overflow pulse lasts one system cycle.
`timescale 1ns/1ps
module interval_base
    import guard_timer_pkg::*;
#(
    parameter int unsigned DIV = INTERVAL_DIV_DEFAULT
)
(
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic clear_i,
    input wire logic [2:0] period_sel_i,
    output logic [7:0] count_o,
    output logic overflow_o
);

    typedef struct packed {
        logic [15:0] div_cnt;
        logic [7:0] count;
        logic ovf;
    } base_state_t;

    base_state_t st_ff;
    base_state_t nxt_st;
    logic [7:0] low_mask;
    logic clk_en;

    // ****************************************************************
    // Divider, counter and overflow selection.
    // ****************************************************************
    always_comb begin
        nxt_st = st_ff;
        nxt_st.ovf = 1'b0;
        low_mask = 8'hff >> (3'h7 - period_sel_i);
        clk_en = (st_ff.div_cnt == 16'(DIV - 1));
        if (clear_i) begin
            nxt_st.count = COUNT_RESET;
            nxt_st.div_cnt = '0;
        end else begin
            nxt_st.div_cnt = clk_en ? '0 : st_ff.div_cnt + 16'h0001;
            if (clk_en) begin
                nxt_st.count = st_ff.count + 8'h01;
                nxt_st.ovf = &(st_ff.count | ~low_mask);
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign count_o = st_ff.count;
    assign overflow_o = st_ff.ovf;

endmodule

// [guard_timer_checker.sv]
// Purpose: Port-level assertions for the guard timer block.
// Assumes: Classic Wishbone slave that answers one cycle after a request.
// Notes: Bound to every instance of the block.
`timescale 1ns/1ps
module guard_timer_checker
    import guard_timer_pkg::*;
#(
    parameter int unsigned INTERVAL_DIV = INTERVAL_DIV_DEFAULT
)
(
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [DATA_W-1:0] wb_dat_i,
    input wire logic [DATA_W-1:0] wb_dat_o,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic rc_clk_i,
    input wire logic interval_irq_ack_i,
    input wire logic guard_irq_ack_i,
    input wire logic interval_irq_flag_o,
    input wire logic guard_irq_flag_o,
    input wire logic irq_o,
    input wire logic cpu_reset_req_o,
    input wire logic rc_osc_enable_o
);
    // ****************************************************************
    // Assertions.
    // ****************************************************************
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (reset_i);

    a_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not answered in one cycle");
    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_read_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000)
        else $error("read data upper bits not zero");
    a_quiet_after_reset: assert property ($fell(reset_i) |-> !irq_o && !cpu_reset_req_o
        && !guard_irq_flag_o && !rc_osc_enable_o && !wb_ack_o)
        else $error("outputs not idle after reset");
    a_clock_select_bit: assert property (wb_ack_o && wb_we_i && wb_sel_i[0]
        && wb_adr_i == byte_addr(IDX_GUARD_CONTROL) |-> ##2
        rc_osc_enable_o == $past(wb_dat_i[GC_CLOCK_SELECT_BIT], 2))
        else $error("oscillator enable does not follow clock select");
    a_reset_one_pulse: assert property (cpu_reset_req_o |=> !cpu_reset_req_o)
        else $error("reset request longer than one cycle");
    a_reset_no_flag: assert property (cpu_reset_req_o |-> !$rose(guard_irq_flag_o))
        else $error("guard flag set in reset mode");
    a_guard_ack_clear: assert property (guard_irq_ack_i && guard_irq_flag_o
        |=> !guard_irq_flag_o)
        else $error("guard flag not cleared by acknowledge");
    a_interval_ack_clear: assert property (interval_irq_ack_i && interval_irq_flag_o
        |=> !interval_irq_flag_o)
        else $error("interval flag not cleared by acknowledge");
endmodule

bind guard_timer_block guard_timer_checker #(
    .INTERVAL_DIV(INTERVAL_DIV)
) u_checker (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_we_i(wb_we_i),
    .wb_sel_i(wb_sel_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o),
    .rc_clk_i(rc_clk_i),
    .interval_irq_ack_i(interval_irq_ack_i),
    .guard_irq_ack_i(guard_irq_ack_i),
    .interval_irq_flag_o(interval_irq_flag_o),
    .guard_irq_flag_o(guard_irq_flag_o),
    .irq_o(irq_o),
    .cpu_reset_req_o(cpu_reset_req_o),
    .rc_osc_enable_o(rc_osc_enable_o)
);

// [guard_timer_block_bench.sv]
// Purpose: Self-checking bench for the guard timer block.
// Assumes: Interval divider shortened to two system cycles.
// Notes: Registers are reached through Wishbone read and write tasks.
`timescale 1ns/1ps
module guard_timer_block_bench
    import guard_timer_pkg::*;
();
    // ****************************************************************
    // Signals and tasks.
    // ****************************************************************
    localparam int unsigned DIV = 2;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic rc = 1'b0;
    logic i_ack = 1'b0;
    logic g_ack = 1'b0;
    logic [3:0] sel = 4'h0;
    logic [ADDR_W-1:0] adr = '0;
    logic [DATA_W-1:0] wdat = '0;
    logic [DATA_W-1:0] rdat;
    logic ack, i_flag, g_flag, irq, cpu_rst, rc_en;
    logic [7:0] rd, rd0;
    int failures = 0;
    int n_checks = 0;
    int n;

    always #2 clk = ~clk;

    guard_timer_block #(.INTERVAL_DIV(DIV)) dut (.sys_clk_i(clk), .reset_i(rst),
        .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_we_i(we), .wb_sel_i(sel),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack), .rc_clk_i(rc),
        .interval_irq_ack_i(i_ack), .guard_irq_ack_i(g_ack), .interval_irq_flag_o(i_flag),
        .guard_irq_flag_o(g_flag), .irq_o(irq), .cpu_reset_req_o(cpu_rst),
        .rc_osc_enable_o(rc_en));

    task automatic complete_run();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic check_bit(input string name, input logic exp, input logic got);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic check_near(input string name, input int exp, input int got, input int tol);
        n_checks++;
        if (got < exp - tol || got > exp + tol) begin
            failures++;
            $display("mismatch %s expected %0d seen %0d", name, exp, got);
        end
    endtask

    task automatic wb_cycle(input logic [7:0] idx, input logic w, input logic [7:0] d,
                            output logic [7:0] q);
        int k;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= 4'hf;
        adr <= byte_addr(idx);
        wdat <= {24'h00_0000, d};
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (ack !== 1'b1 && k < 100);
        q = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        if (k >= 100) begin
            failures++;
            complete_run();
        end
    endtask

    task automatic wb_write(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] q;
        wb_cycle(idx, 1'b1, d, q);
    endtask

    task automatic rise(ref logic flag, output int c);
        c = 0;
        do begin
            @(negedge clk);
            c++;
            if (c > 2000) begin
                failures++;
                complete_run();
            end
        end while (flag !== 1'b1);
    endtask

    task automatic ack_flag(input logic guard);
        @(posedge clk);
        if (guard) g_ack <= 1'b1;
        else i_ack <= 1'b1;
        @(posedge clk);
        g_ack <= 1'b0;
        i_ack <= 1'b0;
        @(negedge clk);
        check_bit("flag after ack", 1'b0, guard ? g_flag : i_flag);
    endtask

    task automatic rc_pulse();
        @(posedge clk);
        rc <= 1'b1;
        repeat (10) @(posedge clk);
        rc <= 1'b0;
        repeat (10) @(posedge clk);
    endtask

    // ****************************************************************
    // Tests.
    // ****************************************************************
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (20) @(posedge clk);
        wb_cycle(IDX_INTERVAL_CONTROL, 1'b0, 8'h00, rd);
        check("interval control", 8'h01, rd & 8'h7f);
        check_bit("interval flag", 1'b1, rd[IC_FLAG_BIT]);
        wb_cycle(IDX_GUARD_CONTROL, 1'b0, 8'h00, rd);
        check("guard control", 8'h00, rd);
        wb_cycle(IDX_GUARD_COUNT, 1'b0, 8'h00, rd);
        check("guard count", 8'h00, rd);
        wb_cycle(IDX_EVENT_MASK, 1'b0, 8'h00, rd);
        check("event mask", 8'h00, rd);
        wb_cycle(8'h80, 1'b0, 8'h00, rd);
        check("unmapped", 8'h00, rd);
        $display("test defaults done");
        for (int p = 0; p < 8; p++) begin
            wb_write(IDX_INTERVAL_CONTROL, 8'h08 | 8'(p));
            wb_write(IDX_INTERVAL_CONTROL, 8'(p));
            rise(i_flag, n);
            check_near("interval period", DIV * (2 << p), n, 3);
            ack_flag(1'b0);
        end
        wb_write(IDX_INTERVAL_CONTROL, 8'h0f);
        wb_cycle(IDX_INTERVAL_CONTROL, 1'b0, 8'h00, rd);
        check("interval control", 8'h07, rd);
        wb_cycle(IDX_INTERVAL_COUNT, 1'b0, 8'h00, rd);
        check_bit("interval count", 1'b1, rd <= 8'h04);
        $display("test interval done");
        wb_write(IDX_EVENT_MASK, 8'h01);
        repeat (3) @(negedge clk);
        check_bit("irq masked in", 1'b1, irq);
        wb_write(IDX_EVENT_STATUS, 8'h07);
        repeat (3) @(negedge clk);
        check_bit("irq cleared", 1'b0, irq);
        wb_write(IDX_EVENT_MASK, 8'h00);
        $display("test irq done");
        wb_write(IDX_INTERVAL_CONTROL, 8'h08);
        wb_write(IDX_GUARD_COUNT, 8'h03);
        wb_write(IDX_GUARD_CONTROL, 8'ha0);
        wb_cycle(IDX_GUARD_CONTROL, 1'b0, 8'h00, rd);
        check("guard control", 8'h80, rd & 8'hfe);
        wb_cycle(IDX_GUARD_COUNT, 1'b0, 8'h00, rd);
        check_bit("count below match", 1'b1, rd <= 8'h03);
        rise(g_flag, n);
        ack_flag(1'b1);
        rise(g_flag, n);
        check_near("guard interval", (3 + 1) * 2 * DIV - 2, n, 1);
        wb_write(IDX_GUARD_CONTROL, 8'h80);
        repeat (2) @(negedge clk);
        check_bit("flag write zero", 1'b0, g_flag);
        $display("test guard done");
        wb_write(IDX_GUARD_CONTROL, 8'h00);
        ack_flag(1'b1);
        wb_cycle(IDX_GUARD_COUNT, 1'b0, 8'h00, rd0);
        repeat (40) @(posedge clk);
        wb_cycle(IDX_GUARD_COUNT, 1'b0, 8'h00, rd);
        check("held count", rd0, rd);
        check_bit("no flag while off", 1'b0, g_flag);
        $display("test disable done");
        wb_write(IDX_GUARD_CONTROL, 8'he0);
        rise(cpu_rst, n);
        check_near("reset interval", (3 + 1) * 2 * DIV, n, 3);
        check_bit("no flag in reset mode", 1'b0, g_flag);
        wb_cycle(IDX_EVENT_STATUS, 1'b0, 8'h00, rd);
        check_bit("reset event", 1'b1, rd[EV_GUARD_RESET_BIT]);
        $display("test reset mode done");
        wb_write(IDX_GUARD_CONTROL, 8'h00);
        wb_write(IDX_GUARD_COUNT, 8'h01);
        wb_write(IDX_GUARD_CONTROL, 8'ha2);
        repeat (2) @(negedge clk);
        check_bit("oscillator enable", 1'b1, rc_en);
        rc_pulse();
        check_bit("one rc tick", 1'b0, g_flag);
        rc_pulse();
        check_bit("two rc ticks", 1'b1, g_flag);
        wb_write(IDX_GUARD_CONTROL, 8'h00);
        $display("test rc clock done");
        complete_run();
    end
endmodule
